/* serial_flash_instruction_framing_test.sv */
// self-checking bench of the serial flash host against a behavioural flash
`default_nettype none
module serial_flash_instruction_framing_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sfh_pkg::*;
    typedef struct {logic [31:0] ctrl; int bits; logic [63:0] cap; logic [31:0] st;} sfh_row_type;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_wr = 32'h0000_0000;
    logic [31:0] wb_dat_rd, q;
    logic wb_ack, flash_sclk, flash_cs_n;
    logic [3:0] io_out, io_oe, io_in;
    logic [63:0] cap;
    int bits, fail_count = 0, samples_checked = 0;
    sfh_row_type rows [12] = '{
        '{32'h0000_0006, 8, 64'h06, 0}, '{32'h0000_0050, 8, 64'h50, 0},
        '{32'h0000_0004, 8, 64'h04, 0}, '{32'h0000_01C7, 8, 64'hC7, 0},
        '{32'h0000_0160, 8, 64'h60, 0}, '{32'h0000_0120, 32, 64'h2012_3456, 0},
        '{32'h0000_0152, 32, 64'h5212_3456, 0}, '{32'h0000_01D8, 32, 64'hD812_3456, 0},
        '{32'h0000_07BB, 24, 64'hBB_46EC, 0}, '{32'h0000_0038, 8, 64'h38, 8},
        '{32'h0000_0120, 8, 64'h2A, 8}, '{32'h0000_00FF, 2, 64'h03, 0}};
    always #2.5 clk_sys = ~clk_sys;
    sfh_host dut_u (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr),
        .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack), .flash_sclk(flash_sclk),
        .flash_cs_n(flash_cs_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in));
    sfh_flash_model flash_u (.clk_sys(clk_sys), .flash_sclk(flash_sclk),
        .flash_cs_n(flash_cs_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
        .cap(cap), .bits(bits));
    task automatic wrap_up();
        $display("checked %0d, failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one classic cycle; ack is sampled at the edge, then the request is released
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_wr <= d;
        wb_sel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_dat_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            wrap_up();
        end
    endtask
    task automatic run(input logic [31:0] c);
        int n;
        wb(1'b1, OFS_CTRL, c | 32'h8000_0000);
        n = 0;
        do begin
            wb(1'b0, OFS_STAT, 32'h0000_0000);
            n++;
        end while (q[SF_BUSY] !== 1'b0 && n < 1000);
        if (n >= 1000) begin
            fail_count++;
            wrap_up();
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        wb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk(q, CTRL_RST);
        wb(1'b0, OFS_STAT, 32'h0000_0000);
        chk(q, 64'h0);
        wb(1'b0, 8'h20, 32'h0000_0000);
        chk(q, 64'h0);
        wb(1'b1, OFS_ADDR, 32'h0012_3456);
        foreach (rows[i]) begin
            run(rows[i].ctrl);
            chk(cap, rows[i].cap);
            chk(64'(bits), 64'(rows[i].bits));
            chk(64'(q[3:0]), 64'(rows[i].st));
        end
        wb(1'b1, OFS_LEN, 32'h0000_0000);
        run(32'h0000_C103);
        chk(cap, 64'h0312_3456);
        wb(1'b0, OFS_RX, 32'h0000_0000);
        chk(q, 64'hA5);
        // cut a frame by reset: pins park and the control register clears
        wb(1'b1, OFS_CTRL, 32'h8000_0120);
        repeat (100) @(posedge clk_sys);
        chk(64'(flash_cs_n), 64'h0);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(64'({flash_cs_n, flash_sclk, io_oe}), 64'h20);
        rstn <= 1'b1;
        wb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk(q, CTRL_RST);
        wrap_up();
    end
endmodule
`default_nettype wire

/* sfh_clkgen.sv */
// serial clock divider with four quarter phases per period
`default_nettype none
module sfh_clkgen (
    // system
    input wire logic clk_sys,
    input wire logic rstn,
    // sequencer side
    sfh_link_if.gen lk
);
    import sfh_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic [1:0] qph;
        logic sclk;
    } sfh_gen_type;

    sfh_gen_type q, n;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    // phases 1 and 2 are clock high; idle parks in phase 3 (clock low)
    always_comb begin
        n = q;
        if (!lk.run) begin
            n.cnt = 8'h00;
            n.qph = 2'h3;
            n.sclk = 1'b0;
        end else if (q.cnt == QTR_LAST) begin
            if (!lk.hold) begin
                n.cnt = 8'h00;
                n.qph = q.qph + 2'h1;
                n.sclk = (n.qph == 2'h1) || (n.qph == 2'h2);
            end
        end else begin
            n.cnt = q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.qph <= 2'h3;
        end else begin
            q <= n;
        end
    end

    assign lk.tick = lk.run && (q.cnt == QTR_LAST);
    assign lk.qph = q.qph;
    assign lk.sclk = q.sclk;
endmodule
`default_nettype wire

/* sfh_flash_model.sv */
// behavioural flash at the far side: captures lane 0 input and answers 03h reads
`default_nettype none
module sfh_flash_model (
    // pins
    input wire logic clk_sys,
    input wire logic flash_sclk,
    input wire logic flash_cs_n,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    output logic [3:0] io_in,
    // observation
    output logic [63:0] cap,
    output int bits
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] RD_BYTE = 8'hA5;
    logic drv = 1'b0;
    logic dbit = 1'b0;
    logic junk = 1'b0;
    int rcnt = 0;
    initial cap = '0;
    initial bits = 0;
    // undriven lanes 0 and 1 must not hold a stale level; lanes 2 and 3 idle high
    always @(posedge clk_sys) junk <= ~junk;
    always @(negedge flash_cs_n) begin
        cap = '0;
        bits = 0;
        rcnt = 0;
    end
    always @(posedge flash_cs_n) drv = 1'b0;
    always @(posedge flash_sclk) if (!flash_cs_n) begin
        rcnt++;
        if (io_oe[0] === 1'b1) begin
            cap = {cap[62:0], io_out[0]};
            bits++;
        end
    end
    // only a plain read gets an answer; any other opcode leaves the lane alone
    always @(negedge flash_sclk) if (!flash_cs_n && rcnt >= 32 && cap[31:24] == 8'h03) begin
        drv = 1'b1;
        dbit = RD_BYTE[7 - ((rcnt - 32) % 8)];
    end
    assign io_in[0] = io_oe[0] ? io_out[0] : junk;
    assign io_in[1] = io_oe[1] ? io_out[1] : (drv ? dbit : junk);
    assign io_in[2] = io_oe[2] ? io_out[2] : 1'b1;
    assign io_in[3] = io_oe[3] ? io_out[3] : 1'b1;
endmodule
`default_nettype wire

/* sfh_host.sv */
// serial flash host: wishbone registers and instruction sequencer
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`default_nettype none
// ----------------------------------------------------------------------
// Overview of operation
// - opcodes 06h, 50h, 04h are single bytes, 8 clocks each in one lane
// - 03h sends three address bytes MSB first; 0Bh adds one dummy byte
// - erase 20h, 52h, D8h carry three address bytes; C7h/60h carry none
// - every byte travels MSB first; returned fields use 1, 2 or 4 lanes
// - program sends 1 to 256 data bytes; more wrap within the page
// - security registers selected by middle address byte 10h, 20h, 30h
// - 3Bh sends opcode and address on one lane, 8 dummy clocks, dual data
// - BBh sends address and mode byte on two lanes, 4 clocks per byte
// - two-lane address puts odd bits on lane 1, even bits on lane 0
// - four-lane address sends nibbles on lanes 3 to 0, high first
// - four-lane data byte takes two clocks, high nibble first
// - 32h sends opcode and address on one lane, data on four lanes
// - 77h sends three four-lane dummy bytes, then the wrap setting byte
// - in four-lane command mode all bytes use four lanes; 38h in, FFh out
// - four-lane command puts opcode nibbles in clocks 0 and 1
// - mode byte upper nibble is F unless continuous read is wanted
// - single-lane double-edge read: opcode 8, address 4, dummy 6 clocks
// - four-lane double-edge read: opcode 2, address 1, dummy 8 clocks
// - chip select falls to start, rises to end; inputs sampled rising
// ----------------------------------------------------------------------
module sfh_host (
    // system
    input wire logic clk_sys,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [sfh_pkg::WB_AW-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_wr,
    output logic [31:0] wb_dat_rd,
    output logic wb_ack,
    // flash pins
    output logic flash_sclk,
    output logic flash_cs_n,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic [3:0] io_in
);
    import sfh_pkg::*;

    typedef struct packed {
        sfh_st_type st;
        logic cs_n;
        logic [3:0] out;
        logic [3:0] oe;
        logic [7:0] sh;
        logic [3:0] bits;
        logic act;
        sfh_lane_type ln;
        logic dtr;
        logic [15:0] cnt;
    } sfh_eng_type;

    typedef struct packed {
        sfh_eng_type eng;
        logic [31:0] cfg;
        logic [31:0] adr;
        logic [15:0] len;
        logic [7:0] tx;
        logic [7:0] rx;
        logic tx_full;
        logic rx_full;
        logic four_lane_command_mode;
        logic go;
        logic ack;
        logic [31:0] dat;
        logic [3:0] s1;
        logic [3:0] s2;
    } sfh_state_type;

    sfh_state_type q, n;
    sfh_link_if lk ();

    sfh_clkgen u_clkgen (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .lk(lk)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic sfh_eng_type enter(sfh_eng_type e, sfh_st_type s, logic [31:0] cfg,
                                          logic [15:0] len, logic four_lane_command_mode);
        enter = e;
        enter.st = s;
        enter.bits = 4'h0;
        enter.dtr = 1'b0;
        enter.cnt = 16'h0000;
        enter.ln = four_lane_command_mode ? LANE_FOUR : LANE_ONE;
        case (s)
            ST_ADDR, ST_MODE: begin
                if (s == ST_ADDR) begin
                    enter.cnt = 16'h0002;
                end
                if (!four_lane_command_mode) begin
                    enter.ln = sfh_lane_type'(cfg[CF_ALN_LSB +: 2]);
                end
                enter.dtr = cfg[CF_DTR];
            end
            ST_DUMMY: enter.cnt = 16'(cfg[CF_DUM_LSB +: DUM_W]) - 16'h0001;
            ST_DATA: begin
                enter.cnt = len;
                if (!four_lane_command_mode) begin
                    enter.ln = sfh_lane_type'(cfg[CF_DLN_LSB +: 2]);
                end
                enter.dtr = cfg[CF_DTR];
            end
            default: enter.cnt = 16'h0000;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // sequencer and register file
    // ----------------------------------------------------------------
    sfh_eng_type e;
    logic take, put, stall, done, launch, req;
    logic [3:0] w, wl, inb;
    logic [1:0] p;
    logic [7:0] rxb;

    always_comb begin
        n = q;
        e = q.eng;
        take = 1'b0;
        put = 1'b0;
        stall = 1'b0;
        done = 1'b0;
        launch = 1'b0;
        rxb = 8'h00;
        inb = 4'h0;
        w = lane_w(q.eng.ln);
        p = lk.qph + 2'h1;
        n.s1 = io_in;
        n.s2 = q.s1;
        n.go = 1'b0;
        if (q.eng.st == ST_IDLE) begin
            if (q.go) begin
                e = enter(e, ST_OPC, q.cfg, q.len, q.four_lane_command_mode);
                e.cs_n = 1'b0;
                launch = 1'b1;
            end
        end else if (lk.tick) begin
            // single edge samples at the falling edge, double edge at both
            if (e.act && (e.dtr ? p[0] : p == 2'h3)) begin
                e.act = 1'b0;
                if (e.st == ST_DUMMY) begin
                    if (e.cnt == 16'h0000) begin
                        e = enter(e, after(ST_DUMMY, q.cfg), q.cfg, q.len, q.four_lane_command_mode);
                    end else begin
                        e.cnt = e.cnt - 16'h0001;
                    end
                end else begin
                    case (w)
                        4'h1: inb = {3'b000, q.s2[1]};
                        4'h2: inb = {2'b00, q.s2[1:0]};
                        default: inb = q.s2;
                    endcase
                    e.sh = (e.sh << w) | {4'h0, inb};
                    e.bits = e.bits - w;
                    if (e.bits == 4'h0) begin
                        if (e.st == ST_DATA && q.cfg[CF_RX]) begin
                            put = 1'b1;
                            rxb = e.sh;
                        end
                        if (e.cnt == 16'h0000) begin
                            e = enter(e, after(e.st, q.cfg), q.cfg, q.len, q.four_lane_command_mode);
                        end else begin
                            e.cnt = e.cnt - 16'h0001;
                        end
                    end
                end
            end
            if (e.st == ST_FIN) begin
                if (p == 2'h0) begin
                    e.st = ST_IDLE;
                    e.cs_n = 1'b1;
                    e.oe = 4'h0;
                    done = 1'b1;
                end
            end else if (!e.act && (e.dtr ? !p[0] : p == 2'h3)) begin
                launch = 1'b1;
            end
        end
        wl = lane_w(e.ln);
        if (launch) begin
            e.act = 1'b1;
            if (e.st == ST_DUMMY) begin
                e.oe = 4'h0;
            end else begin
                if (e.bits == 4'h0) begin
                    e.bits = 4'h8;
                    case (e.st)
                        ST_OPC: e.sh = q.cfg[CF_OPC_LSB +: 8];
                        ST_ADDR: e.sh = q.adr[{e.cnt[1:0], 3'b000} +: 8];
                        ST_MODE: e.sh = q.cfg[CF_CONT] ? q.adr[31:24] : {4'hF, q.adr[27:24]};
                        default: begin
                            if (q.cfg[CF_RX]) begin
                                stall = q.rx_full;
                            end else begin
                                stall = !q.tx_full;
                                take = 1'b1;
                                e.sh = q.tx;
                            end
                        end
                    endcase
                end
                if (e.st == ST_DATA && q.cfg[CF_RX]) begin
                    e.oe = 4'h0;
                end else begin
                    case (wl)
                        4'h1: begin
                            e.out = {3'b000, e.sh[7]};
                            e.oe = 4'h1;
                        end
                        4'h2: begin
                            e.out = {2'b00, e.sh[7:6]};
                            e.oe = 4'h3;
                        end
                        default: begin
                            e.out = e.sh[7:4];
                            e.oe = 4'hF;
                        end
                    endcase
                end
            end
        end
        // a stalled boundary is replayed whole once the transmit byte is there or the receive byte has been read
        if (!stall) begin
            n.eng = e;
            if (take) begin
                n.tx_full = 1'b0;
            end
            if (put) begin
                n.rx = rxb;
                n.rx_full = 1'b1;
            end
            if (done && q.cfg[7:0] == OPC_QUAD_ENTER && !q.four_lane_command_mode) begin
                n.four_lane_command_mode = 1'b1;
            end
            if (done && q.cfg[7:0] == OPC_QUAD_LEAVE && q.four_lane_command_mode) begin
                n.four_lane_command_mode = 1'b0;
            end
        end
        // wishbone: one wait state, ack drops after one cycle
        req = wb_cyc && wb_stb && !q.ack;
        n.ack = req;
        if (req) begin
            n.dat = 32'h0000_0000;
            case (wb_adr)
                OFS_CTRL: begin
                    n.dat = {1'b0, q.cfg[30:0]};
                    if (wb_we && q.eng.st == ST_IDLE && !q.go) begin
                        n.cfg = merge(q.cfg, wb_dat_wr, wb_sel);
                        n.go = wb_dat_wr[CF_GO] && wb_sel[3];
                    end
                end
                OFS_ADDR: begin
                    n.dat = q.adr;
                    if (wb_we && q.eng.st == ST_IDLE && !q.go) begin
                        n.adr = merge(q.adr, wb_dat_wr, wb_sel);
                    end
                end
                OFS_LEN: begin
                    n.dat = {16'h0000, q.len};
                    if (wb_we && q.eng.st == ST_IDLE && !q.go) begin
                        n.len = 16'(merge({16'h0000, q.len}, wb_dat_wr, wb_sel));
                    end
                end
                OFS_TX: begin
                    n.dat = {24'h00_0000, q.tx};
                    // a write into a full holding byte is dropped unless the byte is taken in the same cycle
                    if (wb_we && wb_sel[0] && !n.tx_full) begin
                        n.tx = wb_dat_wr[7:0];
                        n.tx_full = 1'b1;
                    end
                end
                OFS_RX: begin
                    n.dat = {24'h00_0000, q.rx};
                    // a stalled landing is replayed, so it must not swallow the clear
                    if (!wb_we && !(put && !stall)) begin
                        n.rx_full = 1'b0;
                    end
                end
                OFS_STAT: begin
                    n.dat[SF_BUSY] = (q.eng.st != ST_IDLE) || q.go;
                    n.dat[SF_TX_FULL] = q.tx_full;
                    n.dat[SF_RX_FULL] = q.rx_full;
                    n.dat[SF_QUAD_CMD] = q.four_lane_command_mode;
                end
                default: n.dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.eng.st <= ST_IDLE;
            q.eng.cs_n <= 1'b1;
            q.cfg <= CTRL_RST;
            q.adr <= ADDR_RST;
            q.len <= LEN_RST;
        end else begin
            q <= n;
        end
    end

    assign lk.run = (q.eng.st != ST_IDLE);
    assign lk.hold = stall;
    assign flash_sclk = lk.sclk;
    assign flash_cs_n = q.eng.cs_n;
    assign io_out = q.eng.out;
    assign io_oe = q.eng.oe;
    assign wb_dat_rd = q.dat;
    assign wb_ack = q.ack;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_cs_idle_high: assert property (@(posedge clk_sys) disable iff (!rstn)
        q.eng.st == ST_IDLE |-> flash_cs_n)
        else $error("chip select low while idle");

    a_cs_rise_low: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(flash_cs_n) |-> !flash_sclk && !$past(flash_sclk))
        else $error("chip select rose with serial clock high");

    a_opc_first_bit: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(flash_cs_n) && !q.four_lane_command_mode |-> io_oe == 4'h1 && io_out[0] == q.cfg[7])
        else $error("opcode msb not on lane 0 at frame start");

    a_mode_nibble_f: assert property (@(posedge clk_sys) disable iff (!rstn)
        q.eng.st == ST_MODE && q.eng.act && q.eng.bits == 4'h8 && !q.cfg[CF_CONT]
        |-> q.eng.sh[7:4] == 4'hF)
        else $error("mode byte upper nibble not F");

    a_quad_enter: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(flash_cs_n) && q.cfg[7:0] == OPC_QUAD_ENTER && !$past(q.four_lane_command_mode) |-> q.four_lane_command_mode)
        else $error("four lane command mode not entered");

    a_quad_lanes: assert property (@(posedge clk_sys) disable iff (!rstn)
        q.eng.ln == LANE_FOUR && io_oe != 4'h0 && !flash_cs_n |-> io_oe == 4'hF)
        else $error("four lane beat not on all lanes");

    a_dual_lanes: assert property (@(posedge clk_sys) disable iff (!rstn)
        q.eng.ln == LANE_TWO && io_oe != 4'h0 && !flash_cs_n |-> io_oe == 4'h3)
        else $error("two lane beat on wrong lanes");

    a_whole_bytes: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(flash_cs_n) |-> $past(q.eng.bits) == 4'h0)
        else $error("frame ended inside a byte");

    a_no_extra_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
        q.eng.st == ST_ADDR |-> !no_extra(q.cfg[7:0]))
        else $error("address sent after single byte opcode");
endmodule
`default_nettype wire

/* sfh_link_if.sv */
// link between the instruction sequencer and the serial clock generator
`default_nettype none
interface sfh_link_if;
    logic run;
    logic hold;
    logic tick;
    logic [1:0] qph;
    logic sclk;
    modport gen (input run, input hold, output tick, output qph, output sclk);
    modport eng (output run, output hold, input tick, input qph, input sclk);
endinterface
`default_nettype wire

/* sfh_pkg.sv */
// shared constants and types of the serial flash host
`default_nettype none
package sfh_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCLK_PERIOD_NS = 160;
    // four quarter phases make one serial clock period
    localparam int QTR_CYC_RAW = (SCLK_PERIOD_NS / 4) / CLK_PERIOD_NS;
    localparam int QTR_CYC = (QTR_CYC_RAW > 0) ? QTR_CYC_RAW : 1;
    localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int WB_AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_LEN = 8'h08;
    localparam logic [7:0] OFS_TX = 8'h0C;
    localparam logic [7:0] OFS_RX = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // control word fields
    localparam int CF_OPC_LSB = 0;
    localparam int CF_ADDR_EN = 8;
    localparam int CF_MODE_EN = 9;
    localparam int CF_ALN_LSB = 10;
    localparam int CF_DLN_LSB = 12;
    localparam int CF_DATA_EN = 14;
    localparam int CF_RX = 15;
    localparam int CF_DTR = 16;
    localparam int CF_DUM_LSB = 17;
    localparam int DUM_W = 5;
    localparam int CF_CONT = 22;
    localparam int CF_GO = 31;
    // status word fields
    localparam int SF_BUSY = 0;
    localparam int SF_TX_FULL = 1;
    localparam int SF_RX_FULL = 2;
    localparam int SF_QUAD_CMD = 3;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [15:0] LEN_RST = 16'h0000;
    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OPC_SET_WLATCH = 8'h06;
    localparam logic [7:0] OPC_VOL_WEN = 8'h50;
    localparam logic [7:0] OPC_CLR_WLATCH = 8'h04;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_FAST_READ = 8'h0B;
    localparam logic [7:0] OPC_ERASE_4K = 8'h20;
    localparam logic [7:0] OPC_ERASE_32K = 8'h52;
    localparam logic [7:0] OPC_ERASE_64K = 8'hD8;
    localparam logic [7:0] OPC_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OPC_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
    localparam logic [7:0] OPC_SEC_PROG = 8'h42;
    localparam logic [7:0] OPC_SEC_READ = 8'h48;
    localparam logic [7:0] OPC_DUAL_OUT_READ = 8'h3B;
    localparam logic [7:0] OPC_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] OPC_QUAD_PROG = 8'h32;
    localparam logic [7:0] OPC_SET_WRAP = 8'h77;
    localparam logic [7:0] OPC_QUAD_ENTER = 8'h38;
    localparam logic [7:0] OPC_QUAD_LEAVE = 8'hFF;
    localparam logic [7:0] OPC_SET_READ_PARAM = 8'hC0;
    localparam logic [7:0] OPC_WRAP_READ = 8'h0C;
    localparam logic [7:0] OPC_DTR_READ = 8'h0D;
    localparam logic [7:0] OPC_DTR_WRAP_READ = 8'h0E;
    localparam logic [7:0] OPC_DTR_QUAD_READ = 8'hED;
    localparam logic [7:0] SEC_REG1_SEL = 8'h10;
    localparam logic [7:0] SEC_REG2_SEL = 8'h20;
    localparam logic [7:0] SEC_REG3_SEL = 8'h30;
    localparam int PAGE_BYTES = 256;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LANE_ONE = 2'h0,
        LANE_TWO = 2'h1,
        LANE_FOUR = 2'h2
    } sfh_lane_type;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_OPC = 7'h02,
        ST_ADDR = 7'h04,
        ST_MODE = 7'h08,
        ST_DUMMY = 7'h10,
        ST_DATA = 7'h20,
        ST_FIN = 7'h40
    } sfh_st_type;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] lane_w(sfh_lane_type l);
        case (l)
            LANE_TWO: lane_w = 4'h2;
            LANE_FOUR: lane_w = 4'h4;
            default: lane_w = 4'h1;
        endcase
    endfunction
    function automatic logic no_extra(logic [7:0] op);
        no_extra = op inside {OPC_SET_WLATCH, OPC_VOL_WEN, OPC_CLR_WLATCH, OPC_CHIP_ERASE_A,
                              OPC_CHIP_ERASE_B, OPC_QUAD_ENTER, OPC_QUAD_LEAVE};
    endfunction
    // phase order is fixed: opcode, address, mode, dummy, data
    function automatic sfh_st_type after(sfh_st_type s, logic [31:0] cfg);
        if (no_extra(cfg[7:0])) begin
            after = ST_FIN;
        end else if (s == ST_OPC && cfg[CF_ADDR_EN]) begin
            after = ST_ADDR;
        end else if ((s == ST_OPC || s == ST_ADDR) && cfg[CF_MODE_EN]) begin
            after = ST_MODE;
        end else if (s != ST_DUMMY && s != ST_DATA && cfg[CF_DUM_LSB +: DUM_W] != '0) begin
            after = ST_DUMMY;
        end else if (s != ST_DATA && cfg[CF_DATA_EN]) begin
            after = ST_DATA;
        end else begin
            after = ST_FIN;
        end
    endfunction
    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] s);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[8*i +: 8] = d[8*i +: 8];
            end
        end
    endfunction
endpackage
`default_nettype wire
